// ---- core/tsl_thermal_latch.sv ----
// ==========================================================================
// thermal shutdown latch

// Contract
// - With protection enabled and the die over 160 C, all channels power down and alarm goes low.
// - During shutdown the reference and bias stay powered; only channel outputs are cut.
// - Shutdown is latched and holds after the over-temperature indication goes away.
// - Channels stay down until the die cools to about 150 C; earlier clears are ignored.
// - Once cooled, any valid update (command, async load low, toggle) clears shutdown.
// - Each rising edge of chip select/load releases the alarm, whatever the temperature.
// - A set disable bit from the config command keeps the device out of shutdown.
// - The config command is recognised by command code 0111b.
module tsl_thermal_latch #(
  parameter int SYNC_STAGES = 2                           // flip-flops per pin synchroniser
) (
  input  wire logic              core_clk_i,              // 50 MHz clock
  input  wire logic              rstn_i,                  // async reset, active low
  input  wire logic              die_hot_i,               // comparator: die above trip, pin
  input  wire logic              die_cool_i,              // comparator: die below cool, pin
  input  wire logic              chip_select_load_n_i,    // chip select/load pin
  input  wire logic              async_load_n_i,          // async load pin, active low
  input  wire logic              toggle_i,                // toggle pin level
  input  wire tsl_pkg::tsl_cmd_s cmd_i,                   // decoded command, same clock
  output logic                   chan_pwr_en_o,           // channel outputs enabled
  output logic                   ref_bias_en_o,           // reference and bias enabled
  output logic                   over_temp_alarm_n_o,     // alarm pin output value
  output logic                   over_temp_alarm_n_oe_o,  // alarm pin drive enable
  output logic                   thermal_protect_disable_o // disable bit state
);

  // ========================================================================
  // parameter check: one flop alone cannot settle an asynchronous pin
  if (SYNC_STAGES < 2) begin : g_sync_check
    $error("SYNC_STAGES must be at least two");
  end

  // ========================================================================
  // pin synchronisers
  logic [SYNC_STAGES-1:0] hot_s;
  logic [SYNC_STAGES-1:0] cool_s;
  logic [SYNC_STAGES-1:0] csl_s;
  logic [SYNC_STAGES-1:0] ald_s;
  logic [SYNC_STAGES-1:0] tgl_s;
  logic                   csl_d;
  logic                   tgl_d;

  // shift each pin through its chain; idle levels loaded at reset
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      hot_s  <= '0;
      cool_s <= '0;
      csl_s  <= '1;    // chip select idles high
      ald_s  <= '1;    // async load idles high
      tgl_s  <= '0;
      csl_d  <= 1'b1;  // matches idle high, no false edge
      tgl_d  <= 1'b0;
    end else begin
      hot_s  <= {hot_s[SYNC_STAGES-2:0], die_hot_i};
      cool_s <= {cool_s[SYNC_STAGES-2:0], die_cool_i};
      csl_s  <= {csl_s[SYNC_STAGES-2:0], chip_select_load_n_i};
      ald_s  <= {ald_s[SYNC_STAGES-2:0], async_load_n_i};
      tgl_s  <= {tgl_s[SYNC_STAGES-2:0], toggle_i};
      csl_d  <= csl_s[SYNC_STAGES-1];
      tgl_d  <= tgl_s[SYNC_STAGES-1];
    end
  end

  // last stage of each chain, the only taps that logic reads
  wire  hot        = hot_s[SYNC_STAGES-1];
  wire  cooled     = cool_s[SYNC_STAGES-1];
  wire  csl_q      = csl_s[SYNC_STAGES-1];
  wire  ald_q      = ald_s[SYNC_STAGES-1];
  wire  tgl_q      = tgl_s[SYNC_STAGES-1];

  // ========================================================================
  // event decode
  logic thermal_protect_disable;
  logic shut;
  logic alarm;
  wire  csl_rise   = csl_q & ~csl_d;
  wire  cfg_cmd    = cmd_i.valid & (cmd_i.code == tsl_pkg::CMD_CONFIG);
  wire  sw_update  = cmd_i.valid & cmd_i.update;
  wire  tgl_edge   = tgl_q ^ tgl_d;
  wire  any_update = sw_update | ~ald_q | tgl_edge;
  wire  trip       = hot & ~thermal_protect_disable;
  wire  clear_ok   = shut & cooled & any_update & ~hot;

  // ========================================================================
  // config bit
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      thermal_protect_disable <= tsl_pkg::DIS_RESET;
    end else if (cfg_cmd) begin
      thermal_protect_disable <= cmd_i.low[tsl_pkg::DIS_BIT];
    end
  end

  // ========================================================================
  // shutdown latch, trip wins over clear
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      shut <= tsl_pkg::SHUT_RESET;
    end else if (trip) begin
      shut <= 1'b1;
    end else if (clear_ok) begin
      shut <= 1'b0;
    end
  end

  // alarm: set by trip, released by chip select/load rise even while hot;
  // a trip that persists sets it again on the following cycle
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      alarm <= 1'b0;
    end else if (csl_rise) begin
      alarm <= 1'b0;
    end else if (trip) begin
      alarm <= 1'b1;
    end
  end

  // ========================================================================
  // outputs
  assign chan_pwr_en_o             = ~shut;
  assign ref_bias_en_o             = 1'b1;
  assign over_temp_alarm_n_o       = 1'b0;                   // open drain
  assign over_temp_alarm_n_oe_o    = alarm;
  assign thermal_protect_disable_o = thermal_protect_disable;

  // ========================================================================
  // assertions

  // protection enabled and die hot
  sequence hot_seen_s;
    hot & ~thermal_protect_disable;
  endsequence

  // a trip in a cycle with no load edge
  sequence alarm_set_s;
    hot & ~thermal_protect_disable & ~csl_rise;
  endsequence

  // shut down, cooled and no longer hot
  sequence cooled_update_s;
    shut & cooled & ~hot;
  endsequence

  // a trip powers the channels down on the next cycle
  trip_shuts_a: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
    hot_seen_s |=> shut && !chan_pwr_en_o)
    else $error("trip did not shut down");

  // a trip without a load edge pulls the alarm pin
  alarm_sets_a: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
    alarm_set_s |=> over_temp_alarm_n_oe_o)
    else $error("trip did not raise the alarm");

  // the alarm never rises without a trip
  alarm_cause_a: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
    !over_temp_alarm_n_oe_o && !(hot && !thermal_protect_disable) |=>
      !over_temp_alarm_n_oe_o)
    else $error("alarm raised without a trip");

  // shutdown never starts without a trip
  shut_cause_a: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
    !shut && !(hot && !thermal_protect_disable) |=> !shut)
    else $error("shutdown entered without a trip");

  // reference and bias stay up through shutdown
  ref_stays_a: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
    shut |-> ref_bias_en_o)
    else $error("reference dropped in shutdown");

  // no update, no release
  latch_holds_a: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
    shut && !any_update |=> shut)
    else $error("shutdown released without update");

  // no release before the die has cooled
  cool_gate_a: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
    shut && !cooled |=> shut)
    else $error("shutdown cleared while hot");

  // no release while the trip comparator still reads hot
  hot_gate_a: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
    shut && hot |=> shut)
    else $error("shutdown cleared while still over trip");

  // cooled software update restores the channels
  update_clears_a: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
    cooled_update_s ##0 sw_update |=> !shut ##0 chan_pwr_en_o)
    else $error("cooled update did not clear");

  // cooled async load low restores the channels
  load_clears_a: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
    cooled_update_s ##0 !ald_q |=> !shut)
    else $error("cooled async load did not clear");

  // cooled toggle restores the channels
  toggle_clears_a: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
    cooled_update_s ##0 $changed(tgl_q) |=> !shut)
    else $error("cooled toggle did not clear");

  // load edge releases the alarm, hot or not
  csl_release_a: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
    $rose(csl_q) |=> !over_temp_alarm_n_oe_o)
    else $error("alarm not released on load edge");

  // disabled protection never shuts down
  disable_blocks_a: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
    !shut && thermal_protect_disable |=> !shut)
    else $error("shutdown entered while disabled");

  // disable bit only moves on a command strobe
  cfg_hold_a: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
    !cmd_i.valid |=> $stable(thermal_protect_disable_o))
    else $error("disable bit changed without a command");

  // config code loads the disable bit
  cfg_decode_a: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
    cmd_i.valid && cmd_i.code == 4'h7 |=>
      thermal_protect_disable_o == $past(cmd_i.low[1]))
    else $error("config command not decoded");

  // other codes leave the disable bit alone
  cfg_ignore_a: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
    cmd_i.valid && cmd_i.code != 4'h7 |=> $stable(thermal_protect_disable_o))
    else $error("disable bit changed by another command");
endmodule : tsl_thermal_latch

// ---- core/tsl_pkg.sv ----
// ==========================================================================
// thermal shutdown latch shared definitions
package tsl_pkg;
  // config command code in the instruction word
  localparam logic [3:0] CMD_CONFIG      = 4'h7;
  // command field position in the 32-bit instruction word
  localparam int         CMD_MSB         = 23;
  localparam int         CMD_LSB         = 20;
  // disable bit position within the config data nibble
  localparam int         DIS_BIT         = 1;
  // values after reset
  localparam logic       DIS_RESET       = 1'b0;
  localparam logic       SHUT_RESET      = 1'b0;
  // temperature thresholds in degrees celsius
  localparam int         TEMP_TRIP_C     = 160;
  localparam int         TEMP_COOL_C     = 150;

  // decoded command strobe from the serial front end
  typedef struct packed {
    logic       valid;   // one-cycle strobe, word complete
    logic [3:0] code;    // command code
    logic [3:0] low;     // low data nibble
    logic       update;  // command includes a channel update
  } tsl_cmd_s;

  typedef enum logic [1:0] {
    TSL_RUN,
    TSL_SHUT
  } tsl_state_e;
endpackage : tsl_pkg

// ---- dv/tsl_host.sv ----
// ==========================================================================
// host controller model: commands, load strobes, toggle pin
module tsl_host (
  input  wire logic         clk_i,          // bench clock
  output logic              csl_n_o = 1'b1, // chip select/load, idle high
  output logic              ald_n_o = 1'b1, // async load, idle high
  output logic              tog_o   = 1'b0, // toggle pin
  output tsl_pkg::tsl_cmd_s cmd_o   = '0    // decoded command strobe
);
  timeunit 1ns;
  timeprecision 1ns;
  // one-cycle command strobe, launched off the falling edge
  task automatic send(input logic [3:0] code, input logic [3:0] low, input logic upd);
    @(negedge clk_i) cmd_o = {1'b1, code, low, upd};
    @(negedge clk_i) cmd_o = '0;
  endtask : send
  // update: 0 command, 1 async load held low, 2 toggle
  task automatic update(input int kind);
    if (kind == 0) send(4'h3, 4'h0, 1'b1);
    if (kind == 1) @(negedge clk_i) ald_n_o = 1'b0;
    if (kind == 1) repeat (4) @(negedge clk_i);
    if (kind == 2) @(negedge clk_i) tog_o = ~tog_o;
    ald_n_o = 1'b1;
  endtask : update
  // frame end: low then rising edge
  task automatic frame();
    @(negedge clk_i) csl_n_o = 1'b0;
    repeat (2) @(negedge clk_i);
    csl_n_o = 1'b1;
  endtask : frame
endmodule : tsl_host

// ---- dv/thermal_shutdown_latch_test.sv ----
// ==========================================================================
// self-checking bench for the thermal shutdown latch
module thermal_shutdown_latch_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic              clk = 1'b0;
  logic              rstn_i = 1'b0;
  logic              hot = 1'b0;
  logic              cool = 1'b0;
  logic              csl_n, ald_n, tog, chan, refb, al, al_oe, dis;
  tsl_pkg::tsl_cmd_s cmd;
  integer            seed = 32'he7df_bcf6;
  int                failures = 0;
  int                n_compared = 0;
  int                cycles = 0;
  logic [3:0]        code;
  wire               alarm_n = al_oe ? al : 1'b1; // pulled up when released
  wire [3:0]         seen = {chan, alarm_n, refb, dis};
  initial forever #10 clk = ~clk;
  tsl_host i_host (.clk_i(clk), .csl_n_o(csl_n), .ald_n_o(ald_n), .tog_o(tog), .cmd_o(cmd));
  tsl_thermal_latch i_dut (.core_clk_i(clk), .rstn_i, .die_hot_i(hot), .die_cool_i(cool),
    .chip_select_load_n_i(csl_n), .async_load_n_i(ald_n), .toggle_i(tog), .cmd_i(cmd),
    .chan_pwr_en_o(chan), .ref_bias_en_o(refb), .over_temp_alarm_n_o(al),
    .over_temp_alarm_n_oe_o(al_oe), .thermal_protect_disable_o(dis));
  // expected {channels on, alarm pin, ref/bias, disable}
  function automatic logic [3:0] ex(input logic shut, input logic alarm, input logic d);
    return {~shut, ~alarm, 1'b1, d};
  endfunction : ex
  task automatic check(input logic [3:0] s, input logic [3:0] e);
    n_compared++;
    if (s !== e) failures++;
    if (s !== e) $display("mismatch at %0t: seen %h expected %h", $time, s, e);
  endtask : check
  task automatic finish_test();
    $display("compared %0d, failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : finish_test
  // hang guard
  always @(posedge clk) if (++cycles == 2000) begin
    failures++;
    finish_test();
  end
  // trip, early clear, alarm release, clear per update kind, then disable
  initial begin
    repeat (2) @(negedge clk);
    rstn_i = 1'b1;
    check(seen, ex(0, 0, 0));
    for (int k = 0; k < 3; k++) begin
      hot = 1'b1;
      cool = 1'b0;
      repeat (5) @(negedge clk);
      i_host.frame();
      repeat (3) @(negedge clk);
      check(seen, ex(1, 0, 0));
      @(negedge clk);
      check(seen, ex(1, 1, 0));
      hot = 1'b0;
      check(seen, ex(1, 1, 0));
      i_host.update(k);
      repeat (5) @(negedge clk);
      check(seen, ex(1, 1, 0));
      cool = 1'b1;
      i_host.frame();
      repeat (4) @(negedge clk);
      check(seen, ex(1, 0, 0));
      i_host.update(k);
      repeat (6) @(negedge clk);
      check(seen, ex(0, 0, 0));
      $display("trip and clear, update kind %0d done", k);
    end
    code = 4'($random(seed));
    if (code == tsl_pkg::CMD_CONFIG) code = 4'h1;
    i_host.send(code, 4'($random(seed)) | 4'h2, 1'b0);
    check(seen, ex(0, 0, 0));
    i_host.send(tsl_pkg::CMD_CONFIG, 4'h2, 1'b0);
    check(seen, ex(0, 0, 1));
    hot = 1'b1;
    repeat (6) @(negedge clk);
    check(seen, ex(0, 0, 1));
    i_host.send(tsl_pkg::CMD_CONFIG, 4'h0, 1'b0);
    repeat (2) @(negedge clk);
    check(seen, ex(1, 1, 0));
    $display("disable test done");
    finish_test();
  end
endmodule : thermal_shutdown_latch_test
